// *** inc/cci_map.vh ***
// register map, field positions, codes and timing for the chassis command interpreter
`ifndef CCI_MAP_VH
`define CCI_MAP_VH

// register byte offsets
`define CCI_REG_CTRL      6'h00
`define CCI_REG_REQ       6'h04
`define CCI_REG_REQ_EXT   6'h08
`define CCI_REG_STATUS    6'h0C
`define CCI_REG_RESP_LO   6'h10
`define CCI_REG_RESP_HI   6'h14
`define CCI_REG_ADDR_CFG  6'h18
`define CCI_REG_ID_CFG    6'h1C

// control bits
`define CCI_CTRL_START    0
`define CCI_CTRL_CLR_DONE 1

// reset values
`define CCI_RST_REQ       32'h00000000
`define CCI_RST_REQ_EXT   32'h00000000
`define CCI_RST_ADDR_CFG  32'h20202020
`define CCI_RST_ID_CFG    32'h0F002020
`define CCI_CAP_MASK      8'h0F

// network functions and logical unit
`define CCI_NETFN_CHASSIS 6'h00
`define CCI_NETFN_SENSOR  6'h04
`define CCI_LUN_ZERO      2'h0

// chassis class command codes
`define CCI_CMD_GET_CAPS  8'h00
`define CCI_CMD_CTRL      8'h02
`define CCI_CMD_IDENTIFY  8'h04
`define CCI_CMD_RST_CAUSE 8'h07
`define CCI_CMD_SET_BOOT  8'h08
`define CCI_CMD_GET_BOOT  8'h09

// sensor/event class command codes
`define CCI_CMD_SET_EVRX  8'h00
`define CCI_CMD_GET_EVRX  8'h01
`define CCI_CMD_EVF_FIRST 8'h10
`define CCI_CMD_EVF_ARM   8'h11
`define CCI_CMD_EVF_SETID 8'h14
`define CCI_CMD_EVF_GETID 8'h15
`define CCI_CMD_EVF_LAST  8'h17

// chassis control actions
`define CCI_ACT_PWR_DOWN  3'h0
`define CCI_ACT_PWR_UP    3'h1
`define CCI_ACT_PWR_CYCLE 3'h2
`define CCI_ACT_HARD_RST  3'h3
`define CCI_ACT_DIAG_INT  3'h4
`define CCI_ACT_SOFT_OFF  3'h5

// completion codes
`define CCI_CC_OK         8'h00
`define CCI_CC_BAD_PARAM  8'h80
`define CCI_CC_BUSY       8'hC0
`define CCI_CC_INV_CMD    8'hC1
`define CCI_CC_BAD_FIELD  8'hCC

// boot options
`define CCI_BOOT_LAST_SEL 7'h07
`define CCI_BOOT_VERSION  8'h01
`define CCI_CAUSE_CHASSIS 8'h01
`define CCI_CAUSE_UNKNOWN 8'h00

// identify
`define CCI_ID_DEF_SEC    8'h0F

// timing: clock period and pulse widths
`define CCI_CLK_NS        10
`define CCI_RESET_PULSE_NS 1000
`define CCI_DIAG_PULSE_NS  1000
`define CCI_CYCLE_OFF_MS   1000
`define CCI_SECOND_MS      1000

`endif

// *** src/cci_power_seq.v ***
// power, reset and diagnostic interrupt sequencer for chassis control actions
`timescale 1ns/10ps
`include "cci_map.vh"

module cci_power_seq #(
	parameter CYCLE_OFF_CYC = (`CCI_CYCLE_OFF_MS * 1000000) / `CCI_CLK_NS
) (
	// clock and reset
	input  wire       mclk_i,
	input  wire       resetn_i,
	// action request
	input  wire       act_valid_i,
	input  wire [2:0] act_code_i,
	input  wire       power_on_i,
	// controls
	output reg        sys_power_o,
	output reg        sys_reset_o,
	output reg        diag_int_o,
	output reg        soft_off_req_o,
	output wire       busy_o
);
	localparam RESET_CYC = (`CCI_RESET_PULSE_NS + `CCI_CLK_NS - 1) / `CCI_CLK_NS;
	localparam DIAG_CYC  = (`CCI_DIAG_PULSE_NS + `CCI_CLK_NS - 1) / `CCI_CLK_NS;
	localparam S_IDLE    = 2'h0;
	localparam S_OFF     = 2'h1;
	localparam S_PULSE   = 2'h2;

	reg [1:0]  state;
	reg [31:0] count;

	assign busy_o = (state != S_IDLE);

	// action execution; power state comes from the sampled power-good level
	always @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state          <= S_IDLE;
			count          <= 32'h00000000;
			sys_power_o    <= 1'b0;
			sys_reset_o    <= 1'b0;
			diag_int_o     <= 1'b0;
			soft_off_req_o <= 1'b0;
		end else begin
			soft_off_req_o <= 1'b0;
			case (state)
			S_IDLE: begin
				if (act_valid_i) begin
					case (act_code_i)
					// RL7 power down
					`CCI_ACT_PWR_DOWN: begin
						if (power_on_i)
							sys_power_o <= 1'b0;
					end
					// RL8 power up
					`CCI_ACT_PWR_UP: begin
						if (!power_on_i)
							sys_power_o <= 1'b1;
					end
					// RL9 off then on
					`CCI_ACT_PWR_CYCLE: begin
						if (power_on_i) begin
							sys_power_o <= 1'b0;
							count       <= CYCLE_OFF_CYC - 1;
							state       <= S_OFF;
						end
					end
					// RL10 reset when on
					`CCI_ACT_HARD_RST: begin
						if (power_on_i) begin
							sys_reset_o <= 1'b1;
							count       <= RESET_CYC - 1;
							state       <= S_PULSE;
						end
					end
					// RL11 diag when on
					`CCI_ACT_DIAG_INT: begin
						if (power_on_i) begin
							diag_int_o <= 1'b1;
							count      <= DIAG_CYC - 1;
							state      <= S_PULSE;
						end
					end
					// RL6 os agent shutdown
					`CCI_ACT_SOFT_OFF: begin
						soft_off_req_o <= 1'b1;
					end
					default: begin
					end
					endcase
				end
			end
			S_OFF: begin
				if (count == 32'h00000000) begin
					sys_power_o <= 1'b1;
					state       <= S_IDLE;
				end else
					count <= count - 32'h00000001;
			end
			S_PULSE: begin
				if (count == 32'h00000000) begin
					sys_reset_o <= 1'b0;
					diag_int_o  <= 1'b0;
					state       <= S_IDLE;
				end else
					count <= count - 32'h00000001;
			end
			default: state <= S_IDLE;
			endcase
		end
	end
endmodule // cci_power_seq

// *** src/cci_chassis_cmd.v ***
// chassis command interpreter: avalon register file, command decoder and responses
// Functional notes
// RL1: decode only requests to logical unit zero, dispatch on command code byte
// RL2: capabilities query answers completion code then capability flag byte
// RL3: flags: bit3 interlock, bit2 diag interrupt, bit1 secure, bit0 intrusion, 7:4 zero
// RL4: capability bytes three to seven carry the five device addresses in order
// RL5: control actions 0 down, 1 up, 2 cycle, 3 hard reset
// RL6: action 4 pulses diag interrupt, action 5 requests os agent shutdown
// RL7: power down removes power only when power is on
// RL8: power up applies power only when power is off
// RL9: power cycle drops then restores power only when power is on
// RL10: hard reset acts only while power is on
// RL11: diag interrupt pulse acts only while power is on
// RL12: identify supports forced-on as well as timed identify
// RL13: accept restart cause query, set boot options and get boot options
// RL14: boot option selectors 0 to 7 are stored and returned
// RL15: set event receiver is not implemented
// RL16: get event receiver returns own address and logical unit
// RL17: accept event filtering codes 10h to 17h
// RL18: unsupported codes answer invalid command with no data bytes
// RL19: sample power-good before executing any control action
`timescale 1ns/10ps
`include "cci_map.vh"

module cci_chassis_cmd #(
	parameter CYCLE_OFF_CYC = (`CCI_CYCLE_OFF_MS * 1000000) / `CCI_CLK_NS,
	parameter SECOND_CYC    = (`CCI_SECOND_MS * 1000000) / `CCI_CLK_NS
) (
	// clock and reset
	input  wire        mclk_i,
	input  wire        resetn_i,
	// avalon-mm slave
	input  wire [5:0]  avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	input  wire [3:0]  avs_byteenable_i,
	output reg  [31:0] avs_readdata_o,
	output wire        avs_waitrequest_o,
	// system side
	input  wire        power_good_i,
	output wire        sys_power_o,
	output wire        sys_reset_o,
	output wire        front_panel_diag_interrupt_o,
	output wire        soft_off_req_o,
	output wire        identify_o
);
	reg         ack;
	reg  [31:0] req;
	reg  [31:0] req_ext;
	reg  [31:0] addr_cfg;
	reg  [31:0] id_cfg;
	reg         pending;
	reg         done;
	reg         power_on;
	reg  [63:0] resp;
	reg  [3:0]  resp_len;
	reg  [63:0] boot_opt;
	reg  [7:0]  restart_cause;
	reg  [15:0] last_event_id;
	reg  [7:0]  postpone;
	reg         id_force;
	reg  [7:0]  id_sec;
	reg  [31:0] id_pre;
	reg  [63:0] next_resp;
	reg  [3:0]  next_len;
	reg         next_act;
	wire        seq_busy;
	wire        acc;
	wire        wr;
	wire [7:0]  cmd   = req[7:0];
	wire [5:0]  netfn = req[13:8];
	wire [1:0]  logical_unit_number   = req[15:14];
	wire [7:0]  d1    = req[23:16];
	wire [7:0]  d2    = req[31:24];
	wire [3:0]  len   = req_ext[11:8];
	wire [7:0]  caps  = id_cfg[31:24] & `CCI_CAP_MASK;

	// byte-lane merge for register writes
	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  be;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (be[i])
					merge[i*8 +: 8] = data[i*8 +: 8];
		end
	endfunction

	// one wait state per access keeps the read mux off the critical path
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
	assign acc = (avs_read_i | avs_write_i) & ack;
	assign wr  = avs_write_i & ack;
	assign identify_o = id_force | (id_sec != 8'h00);

	always @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i)
			ack <= 1'b0;
		else
			ack <= (avs_read_i | avs_write_i) & ~ack;
	end

	// read data; unmapped offsets read zero
	always @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i)
			avs_readdata_o <= 32'h00000000;
		else if ((avs_read_i & ~ack)) begin
			case (avs_address_i & 6'h3C)
			`CCI_REG_REQ:      avs_readdata_o <= req;
			`CCI_REG_REQ_EXT:  avs_readdata_o <= req_ext;
			`CCI_REG_STATUS:   avs_readdata_o <= {8'h00, restart_cause, 4'h0, resp_len,
				3'h0, identify_o, sys_power_o, power_on, done, pending | seq_busy};
			`CCI_REG_RESP_LO:  avs_readdata_o <= resp[31:0];
			`CCI_REG_RESP_HI:  avs_readdata_o <= resp[63:32];
			`CCI_REG_ADDR_CFG: avs_readdata_o <= addr_cfg;
			`CCI_REG_ID_CFG:   avs_readdata_o <= {caps, 6'h00, id_cfg[17:0]};
			default:           avs_readdata_o <= 32'h00000000;
			endcase
		end
	end

	// software-written registers, start and done handshake
	always @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			req      <= `CCI_RST_REQ;
			req_ext  <= `CCI_RST_REQ_EXT;
			addr_cfg <= `CCI_RST_ADDR_CFG;
			id_cfg   <= `CCI_RST_ID_CFG;
			pending  <= 1'b0;
			done     <= 1'b0;
		end else begin
			pending <= 1'b0;
			if (wr && !pending) begin
				case (avs_address_i & 6'h3C)
				`CCI_REG_REQ:      req <= merge(req, avs_writedata_i, avs_byteenable_i);
				`CCI_REG_REQ_EXT:  req_ext <= merge(req_ext, avs_writedata_i, avs_byteenable_i);
				`CCI_REG_ADDR_CFG: addr_cfg <= merge(addr_cfg, avs_writedata_i, avs_byteenable_i);
				`CCI_REG_ID_CFG:   id_cfg <= merge(id_cfg, avs_writedata_i, avs_byteenable_i);
				default: begin
				end
				endcase
			end
			// a start while the previous start is still pending is ignored
			if (wr && avs_address_i[5:2] == (`CCI_REG_CTRL >> 2) && avs_byteenable_i[0]
				&& avs_writedata_i[`CCI_CTRL_START] && !pending)
				pending <= 1'b1;
			// completion sets done; set wins over a clear in the same cycle
			if (pending)
				done <= 1'b1;
			else if (wr && avs_address_i[5:2] == (`CCI_REG_CTRL >> 2) && avs_byteenable_i[0]
				&& avs_writedata_i[`CCI_CTRL_CLR_DONE])
				done <= 1'b0;
		end
	end

	// command decode: builds the response bytes and length
	always @* begin
		next_resp = 64'h0000000000000000;
		next_len  = 4'h1;
		next_act  = 1'b0;
		next_resp[7:0] = `CCI_CC_INV_CMD;
		// RL1 lun zero only
		if (logical_unit_number == `CCI_LUN_ZERO && netfn == `CCI_NETFN_CHASSIS) begin
			case (cmd)
			// RL2 capabilities
			`CCI_CMD_GET_CAPS: begin
				next_resp[7:0] = `CCI_CC_OK;
				// RL3 capability flags
				next_resp[15:8] = caps;
				// RL4 address bytes
				next_resp[47:16] = addr_cfg;
				next_resp[55:48] = id_cfg[7:0];
				next_len = 4'h7;
			end
			// RL5 control actions
			`CCI_CMD_CTRL: begin
				if (d1 > {5'h00, `CCI_ACT_SOFT_OFF})
					next_resp[7:0] = `CCI_CC_BAD_FIELD;
				else if (seq_busy)
					next_resp[7:0] = `CCI_CC_BUSY;
				else begin
					next_resp[7:0] = `CCI_CC_OK;
					next_act = 1'b1;
				end
			end
			`CCI_CMD_IDENTIFY: next_resp[7:0] = `CCI_CC_OK;
			// RL13 restart cause
			`CCI_CMD_RST_CAUSE: begin
				next_resp[7:0]  = `CCI_CC_OK;
				next_resp[15:8] = restart_cause;
				next_len = 4'h3;
			end
			// RL14 boot selectors
			`CCI_CMD_SET_BOOT: begin
				next_resp[7:0] = (d1[6:0] > `CCI_BOOT_LAST_SEL) ? `CCI_CC_BAD_PARAM : `CCI_CC_OK;
			end
			`CCI_CMD_GET_BOOT: begin
				if (d1[6:0] > `CCI_BOOT_LAST_SEL)
					next_resp[7:0] = `CCI_CC_BAD_PARAM;
				else begin
					next_resp[7:0]   = `CCI_CC_OK;
					next_resp[15:8]  = `CCI_BOOT_VERSION;
					next_resp[23:16] = {1'b0, d1[6:0]};
					next_resp[31:24] = boot_opt[d1[2:0]*8 +: 8];
					next_len = 4'h4;
				end
			end
			// RL18 unsupported code
			default: next_resp[7:0] = `CCI_CC_INV_CMD;
			endcase
		end else if (logical_unit_number == `CCI_LUN_ZERO && netfn == `CCI_NETFN_SENSOR) begin
			// RL15 no event generator
			if (cmd == `CCI_CMD_SET_EVRX)
				next_resp[7:0] = `CCI_CC_INV_CMD;
			// RL16 own address
			else if (cmd == `CCI_CMD_GET_EVRX) begin
				next_resp[7:0]   = `CCI_CC_OK;
				next_resp[15:8]  = id_cfg[15:8];
				next_resp[23:16] = {6'h00, id_cfg[17:16]};
				next_len = 4'h3;
			// RL17 filtering codes
			end else if (cmd >= `CCI_CMD_EVF_FIRST && cmd <= `CCI_CMD_EVF_LAST) begin
				next_resp[7:0] = `CCI_CC_OK;
				if (cmd == `CCI_CMD_EVF_ARM) begin
					next_resp[15:8] = d1;
					next_len = 4'h2;
				end else if (cmd == `CCI_CMD_EVF_GETID) begin
					next_resp[23:8] = last_event_id;
					next_len = 4'h3;
				end
			end
		end
	end

	// response capture and command side effects
	always @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			resp          <= 64'h0000000000000000;
			resp_len      <= 4'h0;
			boot_opt      <= 64'h0000000000000000;
			restart_cause <= `CCI_CAUSE_UNKNOWN;
			last_event_id <= 16'h0000;
			postpone      <= 8'h00;
			power_on      <= 1'b0;
		end else begin
			// RL19 sample power-good
			power_on <= power_good_i;
			if (pending) begin
				resp     <= next_resp;
				resp_len <= next_len;
				if (netfn == `CCI_NETFN_SENSOR && next_resp[7:0] == `CCI_CC_OK) begin
					if (cmd == `CCI_CMD_EVF_SETID)
						last_event_id <= {d2, d1};
					if (cmd == `CCI_CMD_EVF_ARM)
						postpone <= d1;
				end
				if (netfn == `CCI_NETFN_CHASSIS && next_resp[7:0] == `CCI_CC_OK) begin
					// RL14 store option
					if (cmd == `CCI_CMD_SET_BOOT)
						boot_opt[d1[2:0]*8 +: 8] <= d2;
					if (next_act && d1[2:0] != `CCI_ACT_SOFT_OFF)
						restart_cause <= `CCI_CAUSE_CHASSIS;
				end
			end
		end
	end

	// identify: forced on, or timed in whole seconds
	always @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			id_force <= 1'b0;
			id_sec   <= 8'h00;
			id_pre   <= 32'h00000000;
		end else if (pending && netfn == `CCI_NETFN_CHASSIS && logical_unit_number == `CCI_LUN_ZERO
			&& cmd == `CCI_CMD_IDENTIFY) begin
			// RL12 forced-on option
			id_force <= (len >= 4'h2) && d2[0];
			id_sec   <= (len >= 4'h1) ? d1 : `CCI_ID_DEF_SEC;
			id_pre   <= 32'h00000000;
		end else if (id_sec != 8'h00) begin
			if (id_pre == SECOND_CYC - 1) begin
				id_pre <= 32'h00000000;
				id_sec <= id_sec - 8'h01;
			end else
				id_pre <= id_pre + 32'h00000001;
		end
	end

	// RL5 action dispatch
	cci_power_seq #(
		.CYCLE_OFF_CYC (CYCLE_OFF_CYC)
	) u_seq (
		.mclk_i         (mclk_i),
		.resetn_i       (resetn_i),
		.act_valid_i    (pending & next_act),
		.act_code_i     (d1[2:0]),
		.power_on_i     (power_on),
		.sys_power_o    (sys_power_o),
		.sys_reset_o    (sys_reset_o),
		.diag_int_o     (front_panel_diag_interrupt_o),
		.soft_off_req_o (soft_off_req_o),
		.busy_o         (seq_busy)
	);
endmodule // cci_chassis_cmd

// *** test/cci_chassis_cmd_assertions.sv ***
// port checker for the chassis command interpreter
`timescale 1ns/10ps
`include "cci_map.vh"
module cci_chassis_cmd_checker #(
	parameter CYCLE_OFF_CYC = 20,
	parameter SECOND_CYC    = 10
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// bus handshake
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	// system side
	input wire logic power_good_i,
	input wire logic sys_power_o,
	input wire logic sys_reset_o,
	input wire logic front_panel_diag_interrupt_o,
	input wire logic soft_off_req_o
);
	localparam int PULSE_CYC = `CCI_RESET_PULSE_NS / `CCI_CLK_NS;
	wire        req = avs_read_i | avs_write_i;
	logic [7:0] rst_cnt;
	logic [7:0] diag_cnt;
	// pulse lengths, judged when the pulse falls so a short or long pulse both fail
	always @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_cnt  <= 8'h00;
			diag_cnt <= 8'h00;
		end else begin
			rst_cnt  <= sys_reset_o ? rst_cnt + 8'h01 : 8'h00;
			diag_cnt <= front_panel_diag_interrupt_o ? diag_cnt + 8'h01 : 8'h00;
		end
	end
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!resetn_i);
	property p_wait_first;
		req && !$past(req && avs_waitrequest_o) |-> avs_waitrequest_o;
	endproperty
	a_wait_first: assert property (p_wait_first) else $error("no wait state");
	property p_wait_second;
		req && avs_waitrequest_o |=> !avs_waitrequest_o;
	endproperty
	a_wait_second: assert property (p_wait_second) else $error("wait too long");
	property p_wait_idle;
		!req |-> !avs_waitrequest_o;
	endproperty
	a_wait_idle: assert property (p_wait_idle) else $error("wait without access");
	property p_rst_width;
		$fell(sys_reset_o) |-> rst_cnt == PULSE_CYC;
	endproperty
	a_rst_width: assert property (p_rst_width) else $error("reset width");
	property p_diag_width;
		$fell(front_panel_diag_interrupt_o) |-> diag_cnt == PULSE_CYC;
	endproperty
	a_diag_width: assert property (p_diag_width) else $error("diag width");
	property p_soft_one;
		soft_off_req_o |=> !soft_off_req_o;
	endproperty
	a_soft_one: assert property (p_soft_one) else $error("soft-off width");
	property p_rst_power;
		$rose(sys_reset_o) |-> sys_power_o && power_good_i;
	endproperty
	a_rst_power: assert property (p_rst_power) else $error("reset while off");
	property p_diag_power;
		$rose(front_panel_diag_interrupt_o) |-> sys_power_o && power_good_i;
	endproperty
	a_diag_power: assert property (p_diag_power) else $error("diag while off");
	property p_down_good;
		$fell(sys_power_o) |-> $past(power_good_i);
	endproperty
	a_down_good: assert property (p_down_good) else $error("drop while off");
	property p_up_off;
		$rose(sys_power_o) |-> !power_good_i;
	endproperty
	a_up_off: assert property (p_up_off) else $error("raise while on");
	c_rst: cover property ($rose(sys_reset_o));
	c_diag: cover property ($rose(front_panel_diag_interrupt_o));
	c_cycle: cover property ($fell(sys_power_o) ##[1:40] $rose(sys_power_o));
endmodule // cci_chassis_cmd_checker

bind cci_chassis_cmd cci_chassis_cmd_checker #(
	.CYCLE_OFF_CYC(CYCLE_OFF_CYC),
	.SECOND_CYC(SECOND_CYC)
) u_cci_chassis_cmd_checker (
	.mclk_i(mclk_i),
	.resetn_i(resetn_i),
	.avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i),
	.avs_waitrequest_o(avs_waitrequest_o),
	.power_good_i(power_good_i),
	.sys_power_o(sys_power_o),
	.sys_reset_o(sys_reset_o),
	.front_panel_diag_interrupt_o(front_panel_diag_interrupt_o),
	.soft_off_req_o(soft_off_req_o)
);

// *** test/cci_power_supply.sv ***
// system power supply model: power good follows the enable after a delay
`timescale 1ns/10ps
module cci_power_supply #(
	parameter int PG_DELAY = 3
) (
	input  wire logic mclk_i,
	input  wire logic resetn_i,
	input  wire logic sys_power_i,
	output wire logic power_good_o
);
	logic [7:0] hist;
	// a real supply ramps, so good lags the enable both ways
	always @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i)
			hist <= 8'h00;
		else
			hist <= {hist[6:0], sys_power_i};
	end
	assign power_good_o = hist[PG_DELAY-1];
endmodule // cci_power_supply

// *** test/testbench.sv ***
// self-checking bench for the chassis command interpreter
`timescale 1ns/10ps
`include "cci_map.vh"
module testbench;
	logic        mclk_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic [5:0]  avs_address_i = 6'h00;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h00000000;
	wire  [31:0] avs_readdata_o;
	wire         avs_waitrequest_o, power_good_i, sys_power_o, sys_reset_o;
	wire         diag_o, soft_off_req_o, identify_o;
	int          num_errors = 0;
	int          total_checks = 0;
	int          n_rst = 0, n_diag = 0, n_soft = 0, n_off = 0;
	logic [31:0] rd, st, rlo, rhi;
	cci_chassis_cmd #(.CYCLE_OFF_CYC(20), .SECOND_CYC(10)) u_cci_chassis_cmd (
		.mclk_i(mclk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .power_good_i(power_good_i),
		.sys_power_o(sys_power_o), .sys_reset_o(sys_reset_o),
		.front_panel_diag_interrupt_o(diag_o), .soft_off_req_o(soft_off_req_o),
		.identify_o(identify_o));
	cci_power_supply u_cci_power_supply (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.sys_power_i(sys_power_o), .power_good_o(power_good_i));
	always #5 mclk_i = ~mclk_i;
	// cycle counts of each system control, compared as differences;
	// counted on the falling edge so a task reading them at a rising edge never races
	always @(negedge mclk_i) begin
		if (sys_reset_o === 1'b1) n_rst++;
		if (diag_o === 1'b1) n_diag++;
		if (soft_off_req_o === 1'b1) n_soft++;
		if (sys_power_o === 1'b0) n_off++;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// one avalon access; request held until waitrequest is sampled low at a rising edge,
	// read data taken at that same edge, request released right after it
	task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk_i);
		avs_address_i <= a;
		avs_read_i <= ~wr;
		avs_write_i <= wr;
		avs_writedata_i <= d;
		do begin
			@(posedge mclk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0);
		rd = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		chk(n, 32'h2, "wait cycles");
	endtask
	function automatic logic [31:0] rq(logic [7:0] c, logic [5:0] nf, logic [7:0] d1,
		logic [7:0] d2, logic [1:0] ln);
		return {d2, d1, ln, nf, c};
	endfunction
	task cmd(input logic [31:0] req, input logic [3:0] len);
		bus(1'b1, `CCI_REG_REQ, req);
		bus(1'b1, `CCI_REG_REQ_EXT, {20'h00000, len, 8'h00});
		bus(1'b1, `CCI_REG_CTRL, 32'h00000003);
		bus(1'b0, `CCI_REG_STATUS, 32'h0);
		st = rd;
		bus(1'b0, `CCI_REG_RESP_LO, 32'h0);
		rlo = rd;
		bus(1'b0, `CCI_REG_RESP_HI, 32'h0);
		rhi = rd;
		chk(st[1], 32'h1, "done");
	endtask
	task t_regs;
		bus(1'b0, `CCI_REG_ADDR_CFG, 32'h0);
		chk(rd, `CCI_RST_ADDR_CFG, "addr cfg reset");
		bus(1'b0, `CCI_REG_ID_CFG, 32'h0);
		chk(rd, `CCI_RST_ID_CFG, "id cfg reset");
		bus(1'b1, 6'h20, 32'hFFFFFFFF);
		bus(1'b0, 6'h20, 32'h0);
		chk(rd, 32'h0, "unmapped");
		bus(1'b1, `CCI_REG_ADDR_CFG, 32'h44332211);
		$display("regs done");
	endtask
	task t_caps;
		cmd(rq(`CCI_CMD_GET_CAPS, `CCI_NETFN_CHASSIS, 8'h00, 8'h00, 2'h0), 4'h0);
		chk(rlo, 32'h22110F00, "caps lo");
		chk(rhi, 32'h00204433, "caps hi");
		chk(st[11:8], 32'h7, "caps len");
		$display("caps done");
	endtask
	task t_bad;
		logic [31:0] q[4];
		q = '{rq(8'h00, 6'h00, 8'h00, 8'h00, 2'h1), rq(`CCI_CMD_SET_EVRX, `CCI_NETFN_SENSOR,
			8'h00, 8'h00, 2'h0), rq(8'h05, 6'h00, 8'h00, 8'h00, 2'h0), rq(8'h00, 6'h06, 8'h00,
			8'h00, 2'h0)};
		foreach (q[i]) begin
			cmd(q[i], 4'h0);
			chk(rlo[7:0], `CCI_CC_INV_CMD, "refused code");
			chk(st[11:8], 32'h1, "refused len");
		end
		$display("bad done");
	endtask
	task t_boot;
		for (int s = 0; s < 9; s++) begin
			cmd(rq(`CCI_CMD_SET_BOOT, 6'h00, s[7:0], 8'h30 + s[7:0], 2'h0), 4'h2);
			chk(rlo[7:0], (s < 8) ? `CCI_CC_OK : `CCI_CC_BAD_PARAM, "set boot");
		end
		for (int s = 0; s < 9; s++) begin
			cmd(rq(`CCI_CMD_GET_BOOT, 6'h00, s[7:0], 8'h00, 2'h0), 4'h1);
			chk(rlo, (s < 8) ? {8'h30 + s[7:0], s[7:0], 16'h0100} : 32'h80, "get boot");
		end
		$display("boot done");
	endtask
	task t_evt;
		bus(1'b1, `CCI_REG_ID_CFG, 32'h0F014220);
		cmd(rq(`CCI_CMD_GET_EVRX, `CCI_NETFN_SENSOR, 8'h00, 8'h00, 2'h0), 4'h0);
		chk(rlo[23:0], 32'h014200, "event receiver");
		for (int c = 16; c < 24; c++) begin
			cmd(rq(c[7:0], `CCI_NETFN_SENSOR, c[7:0], 8'h00, 2'h0), 4'h2);
			chk(rlo[7:0], `CCI_CC_OK, "event filter");
			if (c == 17) chk(rlo, 32'h00001100, "arm echo");
			if (c == 21) chk(rlo, 32'h00001400, "last event id");
		end
		$display("evt done");
	endtask
	task t_ident;
		cmd(rq(`CCI_CMD_IDENTIFY, 6'h00, 8'h00, 8'h01, 2'h0), 4'h2);
		repeat (200) @(posedge mclk_i);
		chk(identify_o, 32'h1, "forced on");
		cmd(rq(`CCI_CMD_IDENTIFY, 6'h00, 8'h00, 8'h00, 2'h0), 4'h2);
		chk(identify_o, 32'h0, "identify off");
		cmd(rq(`CCI_CMD_IDENTIFY, 6'h00, 8'h02, 8'h00, 2'h0), 4'h1);
		chk(identify_o, 32'h1, "timed on");
		repeat (30) @(posedge mclk_i);
		chk(identify_o, 32'h0, "timed off");
		$display("ident done");
	endtask
	// off = 255 skips the off-cycle count where power is off at the start or end of the window
	task act(input logic [7:0] a, cc, pwr, r, dg, sf, off);
		int b_r, b_d, b_s, b_o;
		b_r = n_rst;
		b_d = n_diag;
		b_s = n_soft;
		b_o = n_off;
		cmd(rq(`CCI_CMD_CTRL, 6'h00, a, 8'h00, 2'h0), 4'h1);
		repeat (200) @(posedge mclk_i);
		chk(rlo[7:0], cc, "ctrl code");
		chk(sys_power_o, pwr, "power");
		chk(n_rst - b_r, r, "reset cycles");
		chk(n_diag - b_d, dg, "diag cycles");
		chk(n_soft - b_s, sf, "soft cycles");
		if (off != 8'hFF) chk(n_off - b_o, off, "off cycles");
	endtask
	task t_power;
		act(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF);
		act(8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF);
		act(8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF);
		act(8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF);
		act(8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'hFF);
		act(8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00);
		act(8'h03, 8'h00, 8'h01, 8'h64, 8'h00, 8'h00, 8'h00);
		act(8'h04, 8'h00, 8'h01, 8'h00, 8'h64, 8'h00, 8'h00);
		act(8'h05, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00);
		act(8'h02, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h14);
		act(8'h06, `CCI_CC_BAD_FIELD, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00);
		// the reset pulse started here still runs for 92 cycles into the next window
		cmd(rq(`CCI_CMD_CTRL, 6'h00, 8'h03, 8'h00, 2'h0), 4'h1);
		act(8'h04, `CCI_CC_BUSY, 8'h01, 8'h5C, 8'h00, 8'h00, 8'h00);
		act(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF);
		cmd(rq(`CCI_CMD_RST_CAUSE, 6'h00, 8'h00, 8'h00, 2'h0), 4'h0);
		chk(rlo[23:0], 32'h000100, "restart cause");
		$display("power done");
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge mclk_i);
		resetn_i <= 1'b1;
		t_regs();
		t_caps();
		t_bad();
		t_boot();
		t_evt();
		t_ident();
		t_power();
		tally_and_finish();
	end
	// hang guard, well past the few thousand cycles the tests take
	initial begin
		repeat (30000) @(posedge mclk_i);
		num_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		tally_and_finish();
	end
endmodule // testbench
